// file: rtl/adc_seq2_ctrl.sv
// Sequencer 2 configuration, primary control register and sequencer 2 stepping.
//
// Behaviour
// - Sequencer 2 runs only when on, not in soft reset, no override.
// - Bit 15 selects timer 2 event stepping, else convert time stepping.
// - Bits 7..0 enable channels 7..0 for the sequence.
// - Control bit 15 gates the FIFO interrupt.
// - Control bit 14 gates the sequencer 2 interrupt.
// - Control bit 13 gates the sequencer 1 interrupt.
// - Control bit 12 gates the compare interrupt.
// - Bits 5 and 4 select external reference, default one.
// - Control bit 3 holds both timers and sequencer 2 in reset.
// - Control bit 2 enables the 32-bit second timer.
// - Control bit 1 enables the 32-bit first timer.
// - Control bit 0 is the master enable.
// - Timers and sequencers run on the prescaled clock tick.
`timescale 1ns/100ps
`default_nettype none
module adc_seq2_ctrl
	import adc_seq2_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [7:0] prescale,
	input wire irq_flags_t irqSources,
	input wire logic overrideMode,
	output logic [2:0] activeChannel,
	output logic convertStrobe,
	output irq_flags_t irqGated,
	output module_ctl_t moduleCtl,
	output logic [31:0] firstTimer,
	output logic [31:0] secondTimer
);

	// ----------------------------------------
	// Bus decode.
	// ----------------------------------------
	logic [15:0] seqTwo_reg;
	logic [15:0] control_reg;
	seq_state_t state_reg;
	logic [2:0] chan_reg;
	logic [15:0] wait_reg;
	logic tick;
	wire request = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire doWrite = request && wb_we_i;
	wire selLow = wb_sel_i[0];
	wire selHigh = wb_sel_i[1];
	wire hitSeq = (wb_adr_i == SEQ_TWO_INDEX);
	wire hitCtl = (wb_adr_i == CONTROL_INDEX);
	wire hitSts = (wb_adr_i == STATUS_INDEX);
	wire [15:0] laneMask = {{8{selHigh}}, {8{selLow}}};
	wire [15:0] seqWriteValue = ((seqTwo_reg & ~laneMask) | (wb_dat_i[15:0] & laneMask))
		& SEQ_TWO_MASK;
	wire [15:0] ctlWriteValue = ((control_reg & ~laneMask) | (wb_dat_i[15:0] & laneMask))
		& CONTROL_MASK;
	wire [15:0] statusWord = {8'h00, 2'b00, state_reg, chan_reg};
	wire [15:0] readMux = hitSeq ? seqTwo_reg
		: (hitCtl ? control_reg : (hitSts ? statusWord : 16'h0000));

	// ----------------------------------------
	// Module level control.
	// ----------------------------------------
	wire moduleOn = control_reg[MASTER_ON_BIT];
	wire softReset = control_reg[SOFT_RESET_BIT];
	wire seqEnable = moduleOn && !softReset && !overrideMode;
	wire timerStep = seqTwo_reg[SEQ_MODE_BIT];
	wire [7:0] chanMask = seqTwo_reg[7:0];
	wire timer1Run = moduleOn && !softReset && control_reg[TIMER1_BIT];
	wire timer2Run = moduleOn && !softReset && control_reg[TIMER2_BIT];
	wire timer2Event = timer2Run && tick && (secondTimer[3:0] == 4'hF);

	// ----------------------------------------
	// Next enabled channel search.
	// ----------------------------------------
	logic [2:0] nextChan;
	logic foundChan;
	always_comb begin
		nextChan = chan_reg;
		foundChan = 1'b0;
		for (int i = 7; i >= 1; i--) begin
			if (chanMask[3'(chan_reg + 3'(i))]) begin
				nextChan = 3'(chan_reg + 3'(i));
				foundChan = 1'b1;
			end
		end
		if (!foundChan && chanMask[chan_reg]) begin
			foundChan = 1'b1;
		end
	end

	adc_prescale_tick u_tick (
		.core_clk(core_clk),
		.srst(srst),
		.prescale(prescale),
		.tick(tick)
	);

	// ----------------------------------------
	// Registers.
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			seqTwo_reg <= SEQ_TWO_RESET;
			control_reg <= CONTROL_RESET;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= request;
			wb_dat_o <= request ? {16'h0000, readMux} : 32'h0000_0000;
			if (doWrite && hitSeq) begin
				seqTwo_reg <= seqWriteValue;
			end
			if (doWrite && hitCtl) begin
				control_reg <= ctlWriteValue;
			end
		end
	end

	// ----------------------------------------
	// Sequencing timers.
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst || softReset) begin
			firstTimer <= 32'h0000_0000;
			secondTimer <= 32'h0000_0000;
		end else begin
			if (timer1Run && tick) begin
				firstTimer <= 32'(firstTimer + 32'h0000_0001);
			end
			if (timer2Run && tick) begin
				secondTimer <= 32'(secondTimer + 32'h0000_0001);
			end
		end
	end

	// ----------------------------------------
	// Sequencer 2 stepping.
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst || !seqEnable) begin
			state_reg <= SEQ_IDLE;
			chan_reg <= 3'b000;
			wait_reg <= 16'h0000;
			convertStrobe <= 1'b0;
			activeChannel <= 3'b000;
		end else begin
			convertStrobe <= 1'b0;
			case (state_reg)
				SEQ_IDLE: begin
					if (foundChan && tick) begin
						chan_reg <= chanMask[chan_reg] ? chan_reg : nextChan;
						activeChannel <= chanMask[chan_reg] ? chan_reg : nextChan;
						convertStrobe <= 1'b1;
						wait_reg <= 16'h0000;
						state_reg <= timerStep ? SEQ_WAIT_TIMER : SEQ_CONVERT;
					end
				end
				SEQ_CONVERT: begin
					if (tick) begin
						wait_reg <= 16'(wait_reg + 16'h0001);
					end
					if (tick && wait_reg == 16'(CONVERT_TICKS - 16'h0001)) begin
						chan_reg <= nextChan;
						state_reg <= foundChan ? SEQ_IDLE : SEQ_IDLE;
					end
				end
				SEQ_WAIT_TIMER: begin
					if (timer2Event) begin
						chan_reg <= nextChan;
						state_reg <= SEQ_IDLE;
					end
				end
				default: begin
					state_reg <= SEQ_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Interrupt gating and module outputs.
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			irqGated <= '0;
			moduleCtl <= '0;
		end else begin
			irqGated.fifo <= irqSources.fifo && control_reg[FIFO_GATE_BIT];
			irqGated.seq2 <= irqSources.seq2 && control_reg[SEQ2_GATE_BIT];
			irqGated.seq1 <= irqSources.seq1 && control_reg[SEQ1_GATE_BIT];
			irqGated.cmp <= irqSources.cmp && control_reg[CMP_GATE_BIT];
			moduleCtl.ref2External <= control_reg[REF2_BIT];
			moduleCtl.ref1External <= control_reg[REF1_BIT];
			moduleCtl.timer1Run <= timer1Run;
			moduleCtl.timer2Run <= timer2Run;
			moduleCtl.moduleReset <= softReset;
			moduleCtl.moduleOn <= moduleOn;
		end
	end

	// ----------------------------------------
	// Checks.
	// ----------------------------------------
	property p_seq_gate;
		@(posedge core_clk) disable iff (srst)
		(!moduleOn || softReset || overrideMode) |=> state_reg == SEQ_IDLE;
	endproperty
	a_seq_gate: assert property (p_seq_gate) else $error("sequencer ran while gated");

	property p_mode_select;
		@(posedge core_clk) disable iff (srst)
		(convertStrobe && $past(seqEnable))
			|-> state_reg == ($past(timerStep) ? SEQ_WAIT_TIMER : SEQ_CONVERT);
	endproperty
	a_mode_select: assert property (p_mode_select) else $error("step mode wrong");

	property p_chan_enabled;
		@(posedge core_clk) disable iff (srst)
		convertStrobe && $stable(chanMask) |-> chanMask[activeChannel];
	endproperty
	a_chan_enabled: assert property (p_chan_enabled) else $error("disabled channel converted");

	property p_fifo_gate;
		@(posedge core_clk) disable iff (srst)
		irqGated.fifo |-> $past(control_reg[FIFO_GATE_BIT]) && $past(irqSources.fifo);
	endproperty
	a_fifo_gate: assert property (p_fifo_gate) else $error("fifo irq leaked");

	property p_seq2_gate;
		@(posedge core_clk) disable iff (srst)
		(irqSources.seq2 && control_reg[SEQ2_GATE_BIT]) |=> irqGated.seq2;
	endproperty
	a_seq2_gate: assert property (p_seq2_gate) else $error("seq2 irq gate wrong");

	property p_seq1_gate;
		@(posedge core_clk) disable iff (srst)
		!control_reg[SEQ1_GATE_BIT] |=> !irqGated.seq1;
	endproperty
	a_seq1_gate: assert property (p_seq1_gate) else $error("seq1 irq leaked");

	property p_cmp_gate;
		@(posedge core_clk) disable iff (srst)
		!control_reg[CMP_GATE_BIT] |=> !irqGated.cmp;
	endproperty
	a_cmp_gate: assert property (p_cmp_gate) else $error("compare irq leaked");

	property p_soft_reset;
		@(posedge core_clk) disable iff (srst)
		softReset |=> secondTimer == 32'h0000_0000 && firstTimer == 32'h0000_0000;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("timers run in soft reset");

	property p_timer2_stop;
		@(posedge core_clk) disable iff (srst)
		!control_reg[TIMER2_BIT] |=> $stable(secondTimer) || secondTimer == 32'h0000_0000;
	endproperty
	a_timer2_stop: assert property (p_timer2_stop) else $error("timer 2 counted while off");

	property p_timer1_stop;
		@(posedge core_clk) disable iff (srst)
		!control_reg[TIMER1_BIT] |=> $stable(firstTimer) || firstTimer == 32'h0000_0000;
	endproperty
	a_timer1_stop: assert property (p_timer1_stop) else $error("timer 1 counted while off");

	property p_reserved;
		@(posedge core_clk) disable iff (srst)
		1'b1 |-> (seqTwo_reg & ~SEQ_TWO_MASK) == 16'h0000 && (control_reg & ~CONTROL_MASK) == 16'h0000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits set");

	property p_ack_one;
		@(posedge core_clk) disable iff (srst)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack held too long");

endmodule
`default_nettype wire

// file: shared/adc_seq2_pkg.sv
// Package with register map, field positions, reset values and timing constants.
package adc_seq2_pkg;

	// ----------------------------------------
	// Register map.
	// ----------------------------------------
	localparam logic [7:0] SEQ_TWO_INDEX = 8'h16;
	localparam logic [7:0] CONTROL_INDEX = 8'h18;
	localparam logic [7:0] STATUS_INDEX = 8'h30;
	localparam logic [7:0] STIM_INDEX = 8'h32;

	// ----------------------------------------
	// Field positions.
	// ----------------------------------------
	localparam int SEQ_MODE_BIT = 15;
	localparam logic [15:0] SEQ_TWO_MASK = 16'h80FF;
	localparam logic [15:0] CONTROL_MASK = 16'hF03F;
	localparam int FIFO_GATE_BIT = 15;
	localparam int SEQ2_GATE_BIT = 14;
	localparam int SEQ1_GATE_BIT = 13;
	localparam int CMP_GATE_BIT = 12;
	localparam int REF2_BIT = 5;
	localparam int REF1_BIT = 4;
	localparam int SOFT_RESET_BIT = 3;
	localparam int TIMER2_BIT = 2;
	localparam int TIMER1_BIT = 1;
	localparam int MASTER_ON_BIT = 0;
	localparam int STIM_FIFO_BIT = 0;
	localparam int STIM_SEQ1_BIT = 1;
	localparam int STIM_CMP_BIT = 2;
	localparam int STIM_OVERRIDE_BIT = 3;

	// ----------------------------------------
	// Reset values.
	// ----------------------------------------
	localparam logic [15:0] SEQ_TWO_RESET = 16'h0000;
	localparam logic [15:0] CONTROL_RESET = 16'h0030;
	localparam logic [15:0] STIM_RESET = 16'h0000;
	localparam logic [7:0] PRESCALE_RESET = 8'h09;

	// ----------------------------------------
	// Timing.
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int CONVERT_TIME_US = 20;
	localparam int CONVERT_CYCLES_INT = (CONVERT_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam logic [15:0] CONVERT_TICKS = 16'(CONVERT_TIME_US);
	localparam logic [31:0] TIMER2_PERIOD_RESET = 32'h0000_0010;

	// ----------------------------------------
	// Types.
	// ----------------------------------------
	typedef struct packed {
		logic fifo;
		logic seq2;
		logic seq1;
		logic cmp;
	} irq_flags_t;

	typedef struct packed {
		logic ref2External;
		logic ref1External;
		logic timer1Run;
		logic timer2Run;
		logic moduleReset;
		logic moduleOn;
	} module_ctl_t;

	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_CONVERT = 3'b010,
		SEQ_WAIT_TIMER = 3'b100
	} seq_state_t;

endpackage

// file: rtl/adc_prescale_tick.sv
// Prescale tick generator: one pulse every prescale plus one clock cycles.
`timescale 1ns/100ps
`default_nettype none
module adc_prescale_tick
	import adc_seq2_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [7:0] prescale,
	output logic tick
);

	logic [7:0] count_reg;
	logic [7:0] count_next;
	wire atEnd = (count_reg >= prescale);

	assign count_next = atEnd ? 8'h00 : 8'(count_reg + 8'h01);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			count_reg <= 8'h00;
			tick <= 1'b0;
		end else begin
			count_reg <= count_next;
			tick <= atEnd;
		end
	end

	property p_tick_period;
		@(posedge core_clk) disable iff (srst)
		(tick && prescale == 8'h03 && $past(prescale) == 8'h03 && $past(prescale, 2) == 8'h03
			&& $past(prescale, 3) == 8'h03 && $past(prescale, 4) == 8'h03)
			|-> !$past(tick) && !$past(tick, 2) && !$past(tick, 3) && $past(tick, 4);
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("prescale tick spacing wrong");

endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Testbench for the sequencer 2 configuration and primary control block.
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import adc_seq2_pkg::*;
;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] datI = 32'h0000_0000;
	logic [31:0] datO;
	logic ack;
	logic [7:0] prescale = 8'h00;
	irq_flags_t irqSrc = 4'h0;
	logic overrideMode = 1'b0;
	logic [2:0] activeChannel;
	logic convertStrobe;
	irq_flags_t irqGated;
	module_ctl_t moduleCtl;
	logic [31:0] firstTimer;
	logic [31:0] secondTimer;
	int n_fail = 0;
	int checks = 0;
	int n;
	int gap;
	logic [31:0] rd;
	logic [31:0] t0;
	logic [15:0] v;
	logic got;
	logic [2:0] c1;
	logic [2:0] c2;
	logic [2:0] c3;

	always #50 core_clk = ~core_clk;

	adc_seq2_ctrl DUT (
		.core_clk(core_clk),
		.srst(srst),
		.wb_cyc_i(cyc),
		.wb_stb_i(cyc),
		.wb_we_i(we),
		.wb_adr_i(adr),
		.wb_sel_i(4'h3),
		.wb_dat_i(datI),
		.wb_dat_o(datO),
		.wb_ack_o(ack),
		.prescale(prescale),
		.irqSources(irqSrc),
		.overrideMode(overrideMode),
		.activeChannel(activeChannel),
		.convertStrobe(convertStrobe),
		.irqGated(irqGated),
		.moduleCtl(moduleCtl),
		.firstTimer(firstTimer),
		.secondTimer(secondTimer)
	);

	// ----------------------------------------
	// Tasks.
	// ----------------------------------------
	task conclude;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		int i;
		i = 0;
		@(posedge core_clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		datI <= {16'h0000, d};
		do begin
			@(posedge core_clk);
			i++;
		end while (ack !== 1'b1 && i < 20);
		rd = datO;
		cyc <= 1'b0;
		we <= 1'b0;
		if (ack !== 1'b1) begin
			n_fail++;
			conclude();
		end
	endtask

	task waitStrobe(input int lim, output logic seen, output logic [2:0] ch, output int cnt);
		seen = 1'b0;
		ch = 3'h0;
		cnt = 0;
		while (!seen && cnt < lim) begin
			@(posedge core_clk);
			cnt++;
			if (convertStrobe === 1'b1) begin
				seen = 1'b1;
				ch = activeChannel;
			end
		end
	endtask

	// ----------------------------------------
	// Main sequence.
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		bus(1'b0, SEQ_TWO_INDEX, 16'h0000);
		chk("seq reset", {16'h0000, SEQ_TWO_RESET}, rd);
		bus(1'b0, CONTROL_INDEX, 16'h0000);
		chk("ctl reset", 32'h0000_0030, rd);
		chk("ctl outputs", 32'h0000_0030, 32'(moduleCtl));
		$display("test reset done");
		bus(1'b1, SEQ_TWO_INDEX, 16'hFFFF);
		bus(1'b0, SEQ_TWO_INDEX, 16'h0000);
		chk("seq reserved", 32'h0000_80FF, rd);
		bus(1'b1, CONTROL_INDEX, 16'h0FC0);
		bus(1'b0, CONTROL_INDEX, 16'h0000);
		chk("ctl reserved", 32'h0000_0000, rd);
		bus(1'b1, 8'h40, 16'hFFFF);
		bus(1'b0, 8'h40, 16'h0000);
		chk("unmapped", 32'h0000_0000, rd);
		bus(1'b1, SEQ_TWO_INDEX, 16'h0000);
		$display("test reserved done");
		for (n = 0; n < 6; n++) begin
			v = 16'h0001 << n;
			bus(1'b1, CONTROL_INDEX, v | 16'h0001);
			repeat (2) @(posedge core_clk);
			chk("ctl bits", 32'({v[5:4], v[1], v[2], v[3], 1'b1}), 32'(moduleCtl));
		end
		irqSrc <= 4'hF;
		for (n = 0; n < 4; n++) begin
			bus(1'b1, CONTROL_INDEX, 16'h1000 << n);
			repeat (2) @(posedge core_clk);
			chk("irq gate", 32'h0000_0001 << n, 32'(irqGated));
		end
		bus(1'b1, CONTROL_INDEX, 16'hF000);
		irqSrc <= 4'h5;
		repeat (3) @(posedge core_clk);
		chk("irq all", 32'h0000_0005, 32'(irqGated));
		irqSrc <= 4'h0;
		$display("test fields done");
		prescale <= 8'h03;
		bus(1'b1, CONTROL_INDEX, 16'h0033);
		t0 = firstTimer;
		for (n = 0; n < 20 && firstTimer === t0; n++) @(posedge core_clk);
		t0 = firstTimer;
		for (n = 0; n < 20 && firstTimer === t0; n++) @(posedge core_clk);
		chk("tick period", 32'h0000_0004, 32'(n));
		chk("timer step", t0 + 32'h0000_0001, firstTimer);
		chk("second idle", 32'h0000_0000, secondTimer);
		bus(1'b1, CONTROL_INDEX, 16'h0035);
		t0 = firstTimer;
		repeat (10) @(posedge core_clk);
		chk("first held", t0, firstTimer);
		chk("second runs", 32'h0000_0001, 32'(secondTimer != 32'h0000_0000));
		bus(1'b1, CONTROL_INDEX, 16'h003D);
		repeat (3) @(posedge core_clk);
		chk("soft first", 32'h0000_0000, firstTimer);
		chk("soft second", 32'h0000_0000, secondTimer);
		$display("test timers done");
		prescale <= 8'h00;
		bus(1'b1, SEQ_TWO_INDEX, 16'h0081);
		bus(1'b1, CONTROL_INDEX, 16'h0031);
		waitStrobe(100, got, c1, gap);
		waitStrobe(100, got, c2, gap);
		chk("convert gap", 32'h0000_0001, 32'(gap >= 20 && gap <= 22));
		waitStrobe(100, got, c3, gap);
		chk("convert seen", 32'h0000_0001, 32'(got));
		chk("convert pair", 32'h0000_0007, 32'(c1 ^ c2));
		chk("convert first", 32'h0000_0001, 32'(c1 == 3'h0 || c1 == 3'h7));
		chk("convert wrap", 32'(c1), 32'(c3));
		bus(1'b1, CONTROL_INDEX, 16'h0035);
		bus(1'b1, SEQ_TWO_INDEX, 16'h8006);
		waitStrobe(100, got, c1, gap);
		waitStrobe(100, got, c2, gap);
		waitStrobe(100, got, c3, gap);
		chk("timer gap", 32'h0000_0010, 32'(gap));
		chk("timer pair", 32'h0000_0003, 32'(c2 ^ c3));
		chk("timer chan", 32'h0000_0001, 32'(c3 == 3'h1 || c3 == 3'h2));
		$display("test sequencer done");
		overrideMode <= 1'b1;
		repeat (3) @(posedge core_clk);
		waitStrobe(60, got, c1, gap);
		chk("override stop", 32'h0000_0000, 32'(got));
		overrideMode <= 1'b0;
		bus(1'b1, CONTROL_INDEX, 16'h003D);
		repeat (3) @(posedge core_clk);
		waitStrobe(60, got, c1, gap);
		chk("soft stop", 32'h0000_0000, 32'(got));
		bus(1'b1, CONTROL_INDEX, 16'h0034);
		repeat (3) @(posedge core_clk);
		waitStrobe(60, got, c1, gap);
		chk("off stop", 32'h0000_0000, 32'(got));
		bus(1'b0, STATUS_INDEX, 16'h0000);
		chk("status idle", 32'h0000_0008, rd);
		bus(1'b1, CONTROL_INDEX, 16'h0035);
		waitStrobe(100, got, c1, gap);
		chk("resume", 32'h0000_0001, 32'(got));
		$display("test gating done");
		conclude();
	end
endmodule
`default_nettype wire
